// ===== asr_pkg.sv
`default_nettype none
package asr_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CONV_TIME_NS = 500;
  localparam int unsigned CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONVERT_START_IN_HIGH_NS = 50;
  localparam int unsigned CONVERT_START_IN_CYC = (CONVERT_START_IN_HIGH_NS * CLK_MHZ + 999) / 1000;
  // Half period must exceed the round trip through both synchronisers
  localparam int unsigned SCLK_HALF_CYC = 12;
  localparam logic [7:0] CONV_CNT_INIT = 8'(CONV_CYC - 1);
  localparam logic [7:0] CONVERT_START_IN_CNT_INIT = 8'(CONVERT_START_IN_CYC - 1);
  localparam logic [7:0] HALF_CNT_INIT = 8'(SCLK_HALF_CYC - 1);
  // Edges after release until the strap synchroniser has flushed
  localparam logic [2:0] STRAP_WAIT = 3'h4;
  // Word layout
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned STEPS = 32;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam int unsigned CMD_WR_BIT = 15;
  localparam int unsigned ADDR_MSB = 14;
  localparam int unsigned ADDR_LSB = 9;
  localparam int unsigned DATA_MSB = 8;
  // Register map
  localparam logic [5:0] ADDR_MODE = 6'h00;
  localparam logic [5:0] ADDR_CFG = 6'h02;
  localparam logic [5:0] ADDR_STACK = 6'h20;
  localparam int unsigned CFG_SEQ_BIT = 0;
  localparam int unsigned CFG_BURST_BIT = 1;
  localparam int unsigned STK_ASEL_LSB = 0;
  localparam int unsigned STK_BSEL_LSB = 3;
  localparam int unsigned STK_LAST_BIT = 8;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [8:0] CFG_RST = 9'h000;
  localparam logic [8:0] STK_RST = 9'h000;
  // Synchroniser idle levels: {convert_start_in, cs_n, sclk, sdi, ser_sel, line_sel}
  localparam logic [5:0] DEV_SYNC_RST = 6'h18;
  localparam logic [2:0] HOST_SYNC_RST = 3'h0;
  typedef enum logic [1:0] {CV_IDLE = 2'b01, CV_RUN = 2'b10} asr_conv_t;
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_LEAD = 5'b00010,
    HS_LOW = 5'b00100,
    HS_HIGH = 5'b01000,
    HS_TAIL = 5'b10000
  } asr_host_t;
endpackage
`default_nettype wire

// ===== asr_if.sv
`default_nettype none
interface asr_if;
  logic convert_start;
  logic busy;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic serial_out_a;
  logic serial_out_a_oe;
  logic serial_out_b;
  logic serial_out_b_oe;
  logic serial_parallel_select;
  logic line_count_select;
  // Resolved line levels, undriven lines read low
  logic serial_out_a_line;
  logic serial_out_b_line;
  assign serial_out_a_line = serial_out_a_oe & serial_out_a;
  assign serial_out_b_line = serial_out_b_oe & serial_out_b;
  modport dev (
    input convert_start, cs_n, sclk, sdi, serial_parallel_select, line_count_select,
    output busy, serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe
  );
  modport host (
    output convert_start, cs_n, sclk, sdi, serial_parallel_select, line_count_select,
    input busy, serial_out_a_line, serial_out_b_line
  );
endinterface
`default_nettype wire

// ===== asr_sync.sv
`default_nettype none
module asr_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk_in)
      begin
        if (!reset_n_in)
        begin
          s1_r[i] <= RST_VAL[i];
          s2_r[i] <= RST_VAL[i];
          s3_r[i] <= RST_VAL[i];
          q_out[i] <= RST_VAL[i];
        end
        else if (clk_en_in)
        begin
          s1_r[i] <= d_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // Change taken once stages two and three agree
          if (s2_r[i] == s3_r[i])
            q_out[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== asr_dev.sv
`default_nettype none
// Summary of operation
// - Convert-start rising edge begins a conversion
// - Busy high during conversion, results after fall
// - Chip-select fall enables outputs, presents MSB
// - Each clock rise shifts out next bit
// - Two-line mode sends A and B together
// - Host holds select low across multi-word frames
// - Single-line mode: all on A, 32 clocks
// - Single-line pair in one or two frames
// - Single-line order is A then B
// - Write: D15 set, six-bit address, nine data
// - Read: D15 clear, address, low bits ignored
// - Read answer comes in the following transfer
// - Register mode returns previously addressed register
// - Writing zero to address zero leaves register mode
// - Readback word carries address in D14:D9
// - Pin sequencer ascends from pair zero
// - Register sequencer has 32 free steps
// - Burst converts whole sequence per start pulse
// - Line count strap caught at reset release
// - Two-line: group A on A, B on B
// - Serial port works only when selected
module asr_dev (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Serial link
  asr_if.dev link,
  // Converter core
  input wire logic [15:0] sample_a_in,
  input wire logic [15:0] sample_b_in,
  output logic [2:0] chan_a_out,
  output logic [3:0] chan_b_out,
  // Configuration straps
  input wire logic sw_mode_in,
  input wire logic seq_pin_in,
  input wire logic burst_pin_in,
  input wire logic [2:0] chsel_in,
  // Status
  output logic reg_mode_out
);
  logic [5:0] pins_f;
  logic conv_f, cs_f, sclk_f, sdi_f, sp_f, lc_f;
  logic conv_q_r, cs_q_r, sclk_q_r;
  logic conv_rise, cs_fall, sclk_rise, exec;
  logic straps_ok_r, two_line_r, sw_r, seqpin_r, burstpin_r;
  logic [2:0] settle_r;
  logic [2:0] lastpair_r;
  logic reg_mode_r;
  logic [5:0] last_addr_r;
  logic [8:0] mode_reg_r, cfg_r;
  logic [8:0] stack_r [asr_pkg::STEPS];
  logic [15:0] res_a_r [asr_pkg::STEPS];
  logic [15:0] res_b_r [asr_pkg::STEPS];
  asr_pkg::asr_conv_t conv_st_r;
  logic [7:0] cnt_r;
  logic [4:0] step_r;
  logic [5:0] nres_r;
  logic busy_r;
  logic [3:0] bitcnt_r;
  logic [15:0] shin_r, sha_r, shb_r;
  logic [6:0] ptr_r, total;
  logic [15:0] cmd;
  logic [5:0] cmd_addr;
  logic [8:0] cmd_data;
  logic cmd_wr, cmd_nop, nxt_rm, seq_on, burst_on, last_step;

  localparam int unsigned STEPS_C = asr_pkg::STEPS;

  asr_sync #(.W(6), .RST_VAL(asr_pkg::DEV_SYNC_RST)) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .d_in({link.convert_start, link.cs_n, link.sclk, link.sdi, link.serial_parallel_select,
           link.line_count_select}),
    .q_out(pins_f)
  );
  assign {conv_f, cs_f, sclk_f, sdi_f, sp_f, lc_f} = pins_f;

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      conv_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      sclk_q_r <= 1'b1;
    end
    else if (clk_en_in)
    begin
      conv_q_r <= conv_f;
      cs_q_r <= cs_f;
      sclk_q_r <= sclk_f;
    end
  end
  assign conv_rise = conv_f & ~conv_q_r;
  assign cs_fall = sp_f & cs_q_r & ~cs_f;
  assign sclk_rise = sp_f & ~cs_f & sclk_f & ~sclk_q_r;
  assign exec = sclk_rise && bitcnt_r == asr_pkg::BIT_LAST;

  // Straps caught once the synchroniser holds the pin levels
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      straps_ok_r <= 1'b0;
      settle_r <= 3'h0;
      two_line_r <= 1'b0;
      sw_r <= 1'b0;
      seqpin_r <= 1'b0;
      burstpin_r <= 1'b0;
      lastpair_r <= 3'h0;
    end
    else if (clk_en_in && !straps_ok_r)
    begin
      if (settle_r != asr_pkg::STRAP_WAIT)
        settle_r <= settle_r + 3'h1;
      else
      begin
        straps_ok_r <= 1'b1;
        two_line_r <= lc_f;
        sw_r <= sw_mode_in;
        seqpin_r <= seq_pin_in;
        burstpin_r <= burst_pin_in;
        lastpair_r <= chsel_in;
      end
    end
  end

  // Command decode
  assign cmd = {shin_r[14:0], sdi_f};
  assign cmd_wr = cmd[asr_pkg::CMD_WR_BIT];
  assign cmd_addr = cmd[asr_pkg::ADDR_MSB:asr_pkg::ADDR_LSB];
  assign cmd_data = cmd[asr_pkg::DATA_MSB:0];
  assign cmd_nop = cmd == 16'h0000 && !reg_mode_r;
  assign nxt_rm = cmd_nop ? reg_mode_r : !(cmd_wr && cmd_addr == asr_pkg::ADDR_MODE && cmd_data == 9'h000);

  function automatic logic mapped(input logic [5:0] a);
    mapped = a == asr_pkg::ADDR_MODE || a == asr_pkg::ADDR_CFG || a >= asr_pkg::ADDR_STACK;
  endfunction

  function automatic logic [8:0] reg_val(input logic [5:0] a);
    reg_val = 9'h000;
    if (a == asr_pkg::ADDR_MODE)
      reg_val = mode_reg_r;
    else if (a == asr_pkg::ADDR_CFG)
      reg_val = cfg_r;
    else if (a >= asr_pkg::ADDR_STACK)
      reg_val = stack_r[a[4:0]];
  endfunction

  function automatic logic [15:0] word_a(input logic [6:0] p);
    word_a = 16'h0000;
    if (!busy_r && p < total)
    begin
      if (two_line_r)
        word_a = res_a_r[p[4:0]];
      else if (p[0])
        word_a = res_b_r[p[5:1]];
      else
        word_a = res_a_r[p[5:1]];
    end
  endfunction

  function automatic logic [15:0] word_b(input logic [6:0] p);
    word_b = 16'h0000;
    if (!busy_r && p < total && two_line_r)
      word_b = res_b_r[p[4:0]];
  endfunction

  assign total = two_line_r ? {1'b0, nres_r} : {nres_r, 1'b0};

  // Register file
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      reg_mode_r <= 1'b0;
      last_addr_r <= asr_pkg::ADDR_MODE;
      mode_reg_r <= asr_pkg::MODE_RST;
      cfg_r <= asr_pkg::CFG_RST;
      for (int i = 0; i < STEPS_C; i++)
        stack_r[i] <= asr_pkg::STK_RST;
    end
    else if (clk_en_in && exec && !cmd_nop)
    begin
      reg_mode_r <= nxt_rm;
      last_addr_r <= cmd_addr;
      if (cmd_wr)
      begin
        if (cmd_addr == asr_pkg::ADDR_MODE)
          mode_reg_r <= cmd_data;
        else if (cmd_addr == asr_pkg::ADDR_CFG)
          cfg_r <= cmd_data;
        else if (cmd_addr >= asr_pkg::ADDR_STACK)
          stack_r[cmd_addr[4:0]] <= cmd_data;
      end
    end
  end

  // Sequencer settings
  assign seq_on = sw_r ? cfg_r[asr_pkg::CFG_SEQ_BIT] : seqpin_r;
  assign burst_on = seq_on & (sw_r ? cfg_r[asr_pkg::CFG_BURST_BIT] : burstpin_r);
  assign last_step = !seq_on || (sw_r ? (stack_r[step_r][asr_pkg::STK_LAST_BIT] || step_r == 5'h1f)
                                      : step_r[2:0] == lastpair_r);

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      chan_a_out <= 3'h0;
      chan_b_out <= 4'h0;
    end
    else if (clk_en_in)
    begin
      if (sw_r)
      begin
        chan_a_out <= stack_r[step_r][asr_pkg::STK_ASEL_LSB +: 3];
        chan_b_out <= stack_r[step_r][asr_pkg::STK_BSEL_LSB +: 4];
      end
      else
      begin
        chan_a_out <= seq_on ? step_r[2:0] : chsel_in;
        chan_b_out <= {1'b0, seq_on ? step_r[2:0] : chsel_in};
      end
    end
  end

  // Conversion control
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      conv_st_r <= asr_pkg::CV_IDLE;
      cnt_r <= 8'h00;
      step_r <= 5'h00;
      nres_r <= 6'h00;
      busy_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      case (conv_st_r)
        asr_pkg::CV_IDLE:
        begin
          if (conv_rise)
          begin
            conv_st_r <= asr_pkg::CV_RUN;
            busy_r <= 1'b1;
            cnt_r <= asr_pkg::CONV_CNT_INIT;
            nres_r <= 6'h00;
          end
        end
        asr_pkg::CV_RUN:
        begin
          if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
          else
          begin
            nres_r <= nres_r + 6'h01;
            if (burst_on && !last_step)
            begin
              step_r <= step_r + 5'h01;
              cnt_r <= asr_pkg::CONV_CNT_INIT;
            end
            else
            begin
              conv_st_r <= asr_pkg::CV_IDLE;
              busy_r <= 1'b0;
              step_r <= last_step ? 5'h00 : step_r + 5'h01;
            end
          end
        end
        default:
        begin
          conv_st_r <= asr_pkg::CV_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < STEPS_C; i++)
      begin
        res_a_r[i] <= 16'h0000;
        res_b_r[i] <= 16'h0000;
      end
    end
    else if (clk_en_in && conv_st_r == asr_pkg::CV_RUN && cnt_r == 8'h00)
    begin
      res_a_r[nres_r[4:0]] <= sample_a_in;
      res_b_r[nres_r[4:0]] <= sample_b_in;
    end
  end

  // Serial shifter
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      bitcnt_r <= 4'h0;
      shin_r <= 16'h0000;
      sha_r <= 16'h0000;
      shb_r <= 16'h0000;
      ptr_r <= 7'h00;
    end
    else if (clk_en_in)
    begin
      if (conv_rise && conv_st_r == asr_pkg::CV_IDLE)
        ptr_r <= 7'h00;
      if (cs_fall)
      begin
        bitcnt_r <= 4'h0;
        sha_r <= reg_mode_r ? {1'b0, last_addr_r, reg_val(last_addr_r)} : word_a(ptr_r);
        shb_r <= reg_mode_r ? 16'h0000 : word_b(ptr_r);
      end
      else if (sclk_rise)
      begin
        bitcnt_r <= bitcnt_r + 4'h1;
        shin_r <= cmd;
        if (exec)
        begin
          if (nxt_rm && !cmd_nop)
          begin
            sha_r <= {1'b0, cmd_addr, cmd_wr ? (mapped(cmd_addr) ? cmd_data : 9'h000) : reg_val(cmd_addr)};
            shb_r <= 16'h0000;
          end
          else if (reg_mode_r)
          begin
            sha_r <= word_a(ptr_r);
            shb_r <= word_b(ptr_r);
          end
          else
          begin
            ptr_r <= ptr_r + 7'h01;
            sha_r <= word_a(ptr_r + 7'h01);
            shb_r <= word_b(ptr_r + 7'h01);
          end
        end
        else
        begin
          sha_r <= {sha_r[14:0], 1'b0};
          shb_r <= {shb_r[14:0], 1'b0};
        end
      end
    end
  end

  // Output enables
  logic oe_a_r, oe_b_r;
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      oe_a_r <= 1'b0;
      oe_b_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      oe_a_r <= sp_f & ~cs_f;
      oe_b_r <= sp_f & ~cs_f & two_line_r;
    end
  end

  assign link.serial_out_a = sha_r[15];
  assign link.serial_out_b = shb_r[15];
  assign link.serial_out_a_oe = oe_a_r;
  assign link.serial_out_b_oe = oe_b_r;
  assign link.busy = busy_r;
  assign reg_mode_out = reg_mode_r;
endmodule
`default_nettype wire

// ===== asr_host.sv
`default_nettype none
module asr_host (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Serial link
  asr_if.host link,
  // Straps
  input wire logic two_line_in,
  input wire logic serial_sel_in,
  // Requests
  input wire logic conv_req_in,
  input wire logic frame_req_in,
  input wire logic [2:0] frame_words_in,
  input wire logic [15:0] tx_word_in,
  // Results
  output logic [15:0] rx_a_out,
  output logic [15:0] rx_b_out,
  output logic rx_valid_out,
  output logic frame_busy_out,
  output logic adc_busy_out
);
  logic [2:0] in_f;
  asr_pkg::asr_host_t st_r;
  logic [7:0] hcnt_r, ccnt_r;
  logic [3:0] bits_r;
  logic [2:0] words_r;
  logic [15:0] tx_r, rxa_r, rxb_r;
  logic cs_r, sclk_r, sdi_r, conv_r, sp_r, lc_r;
  logic half_done, do_fall;

  asr_sync #(.W(3), .RST_VAL(asr_pkg::HOST_SYNC_RST)) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .d_in({link.busy, link.serial_out_a_line, link.serial_out_b_line}),
    .q_out(in_f)
  );

  assign half_done = hcnt_r == 8'h00;
  assign do_fall = half_done && (st_r == asr_pkg::HS_LEAD ||
                   (st_r == asr_pkg::HS_HIGH && (bits_r != asr_pkg::BIT_LAST || words_r != 3'h1)));

  // Convert-start pulse
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      conv_r <= 1'b0;
      ccnt_r <= 8'h00;
    end
    else if (clk_en_in)
    begin
      if (conv_r)
      begin
        if (ccnt_r == 8'h00)
          conv_r <= 1'b0;
        else
          ccnt_r <= ccnt_r - 8'h01;
      end
      else if (conv_req_in)
      begin
        conv_r <= 1'b1;
        ccnt_r <= asr_pkg::CONVERT_START_IN_CNT_INIT;
      end
    end
  end

  // Frame engine: sclk idles high, data sampled and driven at falls
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      st_r <= asr_pkg::HS_IDLE;
      hcnt_r <= 8'h00;
      bits_r <= 4'h0;
      words_r <= 3'h0;
      tx_r <= 16'h0000;
      rxa_r <= 16'h0000;
      rxb_r <= 16'h0000;
      cs_r <= 1'b1;
      sclk_r <= 1'b1;
      sdi_r <= 1'b0;
      rx_a_out <= 16'h0000;
      rx_b_out <= 16'h0000;
      rx_valid_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      rx_valid_out <= 1'b0;
      if (!half_done)
        hcnt_r <= hcnt_r - 8'h01;
      else
        hcnt_r <= asr_pkg::HALF_CNT_INIT;
      if (do_fall)
      begin
        sclk_r <= 1'b0;
        sdi_r <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
        rxa_r <= {rxa_r[14:0], in_f[1]};
        rxb_r <= {rxb_r[14:0], in_f[0]};
      end
      case (st_r)
        asr_pkg::HS_IDLE:
        begin
          if (frame_req_in && frame_words_in != 3'h0)
          begin
            st_r <= asr_pkg::HS_LEAD;
            cs_r <= 1'b0;
            words_r <= frame_words_in;
            tx_r <= tx_word_in;
            bits_r <= 4'h0;
            hcnt_r <= asr_pkg::HALF_CNT_INIT;
          end
        end
        asr_pkg::HS_LEAD:
        begin
          if (half_done)
            st_r <= asr_pkg::HS_LOW;
        end
        asr_pkg::HS_LOW:
        begin
          if (half_done)
          begin
            sclk_r <= 1'b1;
            st_r <= asr_pkg::HS_HIGH;
          end
        end
        asr_pkg::HS_HIGH:
        begin
          if (half_done)
          begin
            bits_r <= bits_r + 4'h1;
            if (bits_r == asr_pkg::BIT_LAST)
            begin
              rx_a_out <= rxa_r;
              rx_b_out <= rxb_r;
              rx_valid_out <= 1'b1;
              words_r <= words_r - 3'h1;
            end
            st_r <= do_fall ? asr_pkg::HS_LOW : asr_pkg::HS_TAIL;
          end
        end
        asr_pkg::HS_TAIL:
        begin
          if (half_done)
          begin
            cs_r <= 1'b1;
            st_r <= asr_pkg::HS_IDLE;
          end
        end
        default:
        begin
          st_r <= asr_pkg::HS_IDLE;
          cs_r <= 1'b1;
          sclk_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      adc_busy_out <= 1'b0;
    else if (clk_en_in)
      adc_busy_out <= in_f[2];
  end

  // Strap pins follow their inputs through reset so the device sees them settled
  always_ff @(posedge sys_clk_in)
  begin
    if (clk_en_in)
    begin
      sp_r <= serial_sel_in;
      lc_r <= two_line_in;
    end
  end

  assign frame_busy_out = ~cs_r;
  assign link.convert_start = conv_r;
  assign link.cs_n = cs_r;
  assign link.sclk = sclk_r;
  assign link.sdi = sdi_r;
  assign link.serial_parallel_select = sp_r;
  assign link.line_count_select = lc_r;
endmodule
`default_nettype wire

// ===== asr_asserts.sv
`default_nettype none
module asr_asserts (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Link signals
  input wire logic convert_start,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out_a,
  input wire logic serial_out_a_oe,
  input wire logic serial_out_b,
  input wire logic serial_out_b_oe,
  input wire logic serial_parallel_select,
  input wire logic line_count_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] start_age_r;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Cycles since convert start was last high
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      start_age_r <= 4'hf;
    else if (convert_start)
      start_age_r <= 4'h0;
    else if (start_age_r != 4'hf)
      start_age_r <= start_age_r + 4'h1;
  end
  sequence s_pulse;
    convert_start ##1 !convert_start;
  endsequence
  sequence s_busy_long;
    busy [*8] ##1 busy [*8];
  endsequence
  chk_start_pulse: assert property ($rose(convert_start) |=> s_pulse)
    else $error("convert start pulse width wrong");
  chk_busy_soon: assert property ($rose(convert_start) && !busy |-> ##[2:8] busy)
    else $error("conversion not started");
  chk_busy_cause: assert property ($rose(busy) |-> start_age_r <= 4'h8)
    else $error("busy rose without convert start");
  chk_busy_long: assert property ($rose(busy) |-> s_busy_long)
    else $error("busy too short");
  chk_idle_off: assert property (cs_n [*8] |-> !serial_out_a_oe && !serial_out_b_oe)
    else $error("output driven outside frame");
  chk_frame_drive: assert property ((!cs_n && serial_parallel_select) [*8] |-> serial_out_a_oe)
    else $error("output not driven in frame");
  chk_cs_enable: assert property ($fell(cs_n) && serial_parallel_select && $past(serial_parallel_select, 8)
    |-> ##[3:7] serial_out_a_oe)
    else $error("select fall did not enable output");
  chk_bit_setup: assert property ($fell(sclk) && !cs_n
    |-> serial_out_a == $past(serial_out_a, 2) && serial_out_b == $past(serial_out_b, 2))
    else $error("data moved before sampling edge");
  chk_desel_quiet: assert property ((!serial_parallel_select) [*8] |-> !serial_out_a_oe)
    else $error("output driven while deselected");
  chk_one_line_b: assert property (!line_count_select |-> !serial_out_b_oe)
    else $error("second line driven in one-line mode");
endmodule
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic two_line = 1'h1, serial_sel = 1'h1, conv_req = 1'h0, frame_req = 1'h0;
  logic sw_mode = 1'h0, seq_pin = 1'h0, burst_pin = 1'h0;
  logic rx_valid, frame_busy, adc_busy, reg_mode;
  logic [2:0] frame_words = 3'h1, chsel = 3'h0, chan_a;
  logic [3:0] chan_b;
  logic [15:0] tx_word = 16'h0000, sa_hi = 16'h0000, sb_hi = 16'h0000, rx_a, rx_b;
  logic [15:0] qa[$], qb[$];
  logic [15:0] rcmd[5] = '{16'hc04d, 16'hc31a, 16'h43ff, 16'h8403, 16'h8000};
  logic [15:0] rexp[5] = '{16'h0000, 16'h404d, 16'h431a, 16'h431a, 16'h0403};
  int errors = 0, checked = 0;
  asr_if link ();
  always #12.5 sys_clk_in = ~sys_clk_in;
  asr_host i_asr_host (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'h1), .link(link.host),
    .two_line_in(two_line), .serial_sel_in(serial_sel), .conv_req_in(conv_req), .frame_req_in(frame_req),
    .frame_words_in(frame_words), .tx_word_in(tx_word), .rx_a_out(rx_a), .rx_b_out(rx_b),
    .rx_valid_out(rx_valid), .frame_busy_out(frame_busy), .adc_busy_out(adc_busy));
  asr_dev i_asr_dev (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'h1), .link(link.dev),
    .sample_a_in({sa_hi[15:3], chan_a}), .sample_b_in({sb_hi[15:4], chan_b}), .chan_a_out(chan_a),
    .chan_b_out(chan_b), .sw_mode_in(sw_mode), .seq_pin_in(seq_pin), .burst_pin_in(burst_pin),
    .chsel_in(chsel), .reg_mode_out(reg_mode));
  asr_asserts i_asr_asserts (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .convert_start(link.convert_start), .busy(link.busy), .cs_n(link.cs_n), .sclk(link.sclk),
    .serial_out_a(link.serial_out_a), .serial_out_a_oe(link.serial_out_a_oe),
    .serial_out_b(link.serial_out_b), .serial_out_b_oe(link.serial_out_b_oe),
    .serial_parallel_select(link.serial_parallel_select), .line_count_select(link.line_count_select));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic expw(input logic [15:0] a, input logic [15:0] b);
    qa.push_back(a);
    qb.push_back(b);
  endtask
  function automatic logic [15:0] ea(input int c);
    return {sa_hi[15:3], 3'(c)};
  endfunction
  function automatic logic [15:0] eb(input int c);
    return {sb_hi[15:4], 4'(c)};
  endfunction
  task automatic conv();
    int t;
    t = 0;
    conv_req = 1'h1;
    tick(1);
    conv_req = 1'h0;
    while (adc_busy !== 1'h1 && t < 40)
    begin
      tick(1);
      t++;
    end
    while (adc_busy !== 1'h0 && t < 400)
    begin
      tick(1);
      t++;
    end
    if (t >= 400)
      errors++;
    tick(4);
  endtask
  task automatic frame(input int n, input logic [15:0] tx);
    int t;
    frame_words = 3'(n);
    tx_word = tx;
    frame_req = 1'h1;
    tick(1);
    frame_req = 1'h0;
    for (int k = 0; k < n; k++)
    begin
      t = 0;
      do
      begin
        tick(1);
        t++;
      end
      while (rx_valid !== 1'h1 && t < 600);
      chk(rx_a, qa.pop_front());
      chk(rx_b, qb.pop_front());
    end
    t = 0;
    while (frame_busy !== 1'h0 && t < 100)
    begin
      tick(1);
      t++;
    end
    tick(10);
  endtask
  task automatic restart(input logic tl, input logic sw, input logic sq, input logic bu, input logic [2:0] ch);
    two_line = tl;
    sw_mode = sw;
    seq_pin = sq;
    burst_pin = bu;
    chsel = ch;
    tick(8);
    reset_n_in = 1'h0;
    tick(6);
    reset_n_in = 1'h1;
    tick(8);
  endtask
  task automatic end_of_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge sys_clk_in);
    errors++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h063a8b60));
    sa_hi = 16'($urandom());
    sb_hi = 16'($urandom());
    chsel = 3'($urandom());
    tick(6);
    reset_n_in = 1'h1;
    tick(8);
    // Two lines, one pair, then an empty word
    conv();
    expw(ea(chsel), eb(chsel));
    expw(16'h0000, 16'h0000);
    frame(2, 16'h0000);
    // Deselected frame reads nothing and leaves the pointer
    chsel = 3'($urandom());
    conv();
    serial_sel = 1'h0;
    tick(8);
    expw(16'h0000, 16'h0000);
    frame(1, 16'h0000);
    serial_sel = 1'h1;
    tick(8);
    expw(ea(chsel), eb(chsel));
    frame(1, 16'h0000);
    // Pin burst over pairs 0 to 3
    restart(1'h1, 1'h0, 1'h1, 1'h1, 3'h3);
    conv();
    for (int k = 0; k < 4; k++)
      expw(ea(k), eb(k));
    expw(16'h0000, 16'h0000);
    frame(5, 16'h0000);
    // One line: one frame of two words, then two frames
    restart(1'h0, 1'h0, 1'h0, 1'h0, 3'($urandom()));
    conv();
    expw(ea(chsel), 16'h0000);
    expw(eb(chsel), 16'h0000);
    frame(2, 16'h0000);
    conv();
    expw(ea(chsel), 16'h0000);
    frame(1, 16'h0000);
    expw(eb(chsel), 16'h0000);
    frame(1, 16'h0000);
    // Register writes and reads, then exit
    restart(1'h1, 1'h1, 1'h0, 1'h0, 3'h0);
    for (int i = 0; i < 5; i++)
    begin
      expw(rexp[i], 16'h0000);
      frame(1, rcmd[i]);
      chk({15'h0000, reg_mode}, 16'(i < 4));
    end
    // Stack steps in burst
    conv();
    expw(ea(5), eb(9));
    expw(ea(2), eb(3));
    expw(16'h0000, 16'h0000);
    frame(3, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
